// ---- hw/ddr3_dual_channel_mapper.sv ----
// top of the dual-channel organisation and address mapper
`timescale 1ns/1ps
`include "ddr3_map_params.svh"
module ddr3_dual_channel_mapper
    import ddr3_map_pkg::*;
#(
    parameter int ADDR_W = 36
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // module population, slot order [ch*2+slot]
    input ddr3_map_pkg::module_info_t i_mod0,
    input ddr3_map_pkg::module_info_t i_mod1,
    input ddr3_map_pkg::module_info_t i_mod2,
    input ddr3_map_pkg::module_info_t i_mod3,
    // configuration
    input wire logic i_cfg_load,
    input wire logic i_want_one_clk,
    input wire logic i_a_is_phys1,
    // request from the processor side
    input wire logic i_req_valid,
    input wire logic [ADDR_W-1:0] i_req_addr,
    input wire logic i_req_write,
    output logic o_req_ready,
    // channel 0 request and completion
    output logic o_ch0_valid,
    output ddr3_map_pkg::chan_req_t o_ch0_req,
    input wire logic i_ch0_done,
    // channel 1 request and completion
    output logic o_ch1_valid,
    output ddr3_map_pkg::chan_req_t o_ch1_req,
    input wire logic i_ch1_done,
    // status
    output ddr3_map_pkg::org_mode_t o_mode,
    output logic o_rate_1333,
    output logic o_cfg_error,
    output ddr3_map_pkg::chan_timing_t o_ch0_timing,
    output ddr3_map_pkg::chan_timing_t o_ch1_timing
);
    // capacity of a channel in GB units; 4 bits per module, summed
    function automatic logic [4:0] chan_size(input module_info_t s0, input module_info_t s1);
        chan_size = (s0.present ? {1'b0, s0.size_gb} : 5'h00) + (s1.present ? {1'b0, s1.size_gb} : 5'h00);
    endfunction

    // module geometry supported by the decoder
    function automatic logic geom_ok(input module_info_t m);
        geom_ok = !m.present || (m.row_bits >= `ROW_MIN && m.row_bits <= `ROW_MAX);
    endfunction

    module_info_t mods [4]; // slot array, two per channel
    assign mods[0] = i_mod0;
    assign mods[1] = i_mod1;
    assign mods[2] = i_mod2;
    assign mods[3] = i_mod3;

    // configuration state
    org_mode_t mode_r, mode_nxt;
    logic rate_r, rate_nxt; // common rate
    logic err_r, err_nxt; // unsupported population
    logic big_r, big_nxt; // physical index of the larger channel
    logic single_r, single_nxt; // physical channel used in single mode
    logic [ADDR_W-1:0] zone_r, zone_nxt; // byte size of symmetric zone, both channels
    logic [4:0] size0, size1;
    logic geom_all;
    logic slow_rate;
    logic [3:0] geo_ok;

    // per-slot geometry check
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_geom
            assign geo_ok[g] = geom_ok(mods[g]);
        end
    endgenerate

    // derive organisation from the population when loaded
    always_comb begin
        size0 = chan_size(mods[0], mods[1]);
        size1 = chan_size(mods[2], mods[3]);
        geom_all = &geo_ok;
        // any present module limited to the lower rate pulls everyone down
        slow_rate = (mods[0].present && !mods[0].rate_1333) || (mods[1].present && !mods[1].rate_1333) ||
                    (mods[2].present && !mods[2].rate_1333) || (mods[3].present && !mods[3].rate_1333);
        mode_nxt = mode_r;
        rate_nxt = rate_r;
        err_nxt = err_r;
        big_nxt = big_r;
        single_nxt = single_r;
        zone_nxt = zone_r;
        if (i_cfg_load) begin
            rate_nxt = slow_rate ? `RATE_1066 : `RATE_1333;
            big_nxt = (size1 > size0);
            // logical A must be the larger channel
            err_nxt = !geom_all || (i_a_is_phys1 ? (size1 < size0) : (size0 < size1));
            zone_nxt = '0;
            if (size0 != 5'h00 && size1 != 5'h00) begin
                // both populated, dual modes; densities may differ
                mode_nxt = (size0 == size1) ? MODE_SYMMETRIC : MODE_ZONED;
                // symmetric zone is twice the smaller channel
                // sizes count whole gigabytes, so placing the smaller one at bit 31 already doubles it
                zone_nxt = ADDR_W'({((size0 < size1) ? size0 : size1), 31'h0});
            end else if (size0 != 5'h00 || size1 != 5'h00) begin
                mode_nxt = MODE_SINGLE;
                single_nxt = (size1 != 5'h00);
            end else begin
                mode_nxt = MODE_NONE;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            mode_r <= MODE_NONE;
            rate_r <= `RATE_1066;
            err_r <= 1'b0;
            big_r <= 1'b0;
            single_r <= 1'b0;
            zone_r <= '0;
        end else begin
            mode_r <= mode_nxt;
            rate_r <= rate_nxt;
            err_r <= err_nxt;
            big_r <= big_nxt;
            single_r <= single_nxt;
            zone_r <= zone_nxt;
        end
    end

    assign o_mode = mode_r;
    assign o_rate_1333 = rate_r;
    assign o_cfg_error = err_r;

    // channel timing selection
    ddr3_chan_timing u_tim0 (
        .i_slot0(mods[0]),
        .i_slot1(mods[1]),
        .i_rate_1333(rate_r),
        .i_want_one_clk(i_want_one_clk),
        .o_timing(o_ch0_timing)
    );
    ddr3_chan_timing u_tim1 (
        .i_slot0(mods[2]),
        .i_slot1(mods[3]),
        .i_rate_1333(rate_r),
        .i_want_one_clk(i_want_one_clk),
        .o_timing(o_ch1_timing)
    );

    // address steering
    logic tgt; // physical channel chosen
    logic [ADDR_W-1:0] off; // channel-local byte offset
    logic [ADDR_W-1:0] line_off; // interleaved offset with bit 6 squeezed out
    logic map_ok; // mode allows traffic
    logic [1:0] busy_r, busy_nxt; // request pending per channel
    logic [1:0] pace_ok;
    logic [1:0] issue;
    logic accept;

    always_comb begin
        line_off = {1'b0, i_req_addr[ADDR_W-1:`LINE_BIT+1], i_req_addr[`LINE_BIT-1:0]};
        map_ok = (mode_r != MODE_NONE) && !err_r;
        tgt = 1'b0;
        off = i_req_addr;
        case (mode_r)
            MODE_SINGLE: begin
                tgt = single_r;
                off = i_req_addr;
            end
            MODE_SYMMETRIC: begin
                tgt = i_req_addr[`LINE_BIT];
                off = line_off;
            end
            MODE_ZONED: begin
                if (i_req_addr < zone_r) begin
                    tgt = i_req_addr[`LINE_BIT];
                    off = line_off;
                end else begin
                    tgt = big_r;
                    off = i_req_addr - (zone_r >> 1);
                end
            end
            default: begin
                tgt = 1'b0;
                off = i_req_addr;
            end
        endcase
        // a busy channel blocks only itself, the other stays open
        accept = i_req_valid && map_ok && !busy_r[tgt] && pace_ok[tgt];
        issue = {accept && tgt, accept && !tgt};
        busy_nxt = (busy_r | issue) & ~{i_ch1_done, i_ch0_done};
        busy_nxt = busy_nxt | issue;
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            busy_r <= 2'b00;
            o_ch0_valid <= 1'b0;
            o_ch1_valid <= 1'b0;
            o_ch0_req <= '0;
            o_ch1_req <= '0;
        end else begin
            busy_r <= busy_nxt;
            o_ch0_valid <= issue[0];
            o_ch1_valid <= issue[1];
            if (issue[0]) begin
                o_ch0_req <= '{offset: 36'(off), write: i_req_write};
            end
            if (issue[1]) begin
                o_ch1_req <= '{offset: 36'(off), write: i_req_write};
            end
        end
    end

    assign o_req_ready = map_ok && !busy_r[tgt] && pace_ok[tgt];

    // command-rate pacing per channel
    ddr3_cmd_pacer u_pace0 (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_two_clk(o_ch0_timing.two_clk),
        .i_issue(issue[0]),
        .o_ready(pace_ok[0])
    );
    ddr3_cmd_pacer u_pace1 (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_two_clk(o_ch1_timing.two_clk),
        .i_issue(issue[1]),
        .o_ready(pace_ok[1])
    );

    // single mode on channel 0 leaves channel 1 silent
    single_route_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (mode_r == MODE_SINGLE && !single_r) |-> !issue[1]) else $error("single mode hit idle channel");
    // single mode on channel 1 leaves channel 0 silent
    single_route1_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (mode_r == MODE_SINGLE && single_r) |-> !issue[0]) else $error("single mode hit idle channel 0");
    // single mode passes the byte address through unchanged
    single_offset_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (mode_r == MODE_SINGLE && accept) |=>
        ((o_ch0_valid ? o_ch0_req.offset : o_ch1_req.offset) == 36'($past(i_req_addr))))
        else $error("single mode offset altered");
    // the strobe that appears belongs to the line's channel
    line_alt_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (mode_r == MODE_SYMMETRIC && accept) |=> ($past(i_req_addr[`LINE_BIT]) ? o_ch1_valid : o_ch0_valid))
        else $error("line steering wrong");
    // the interleaved zone holds whole line pairs and is never empty in dual modes
    zone_shape_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (mode_r == MODE_ZONED || mode_r == MODE_SYMMETRIC) |-> (zone_r != '0 && zone_r[`LINE_BIT:0] == '0))
        else $error("symmetric zone malformed");
    // low-zone requests of zoned mode still alternate by line
    zone_low_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (mode_r == MODE_ZONED && accept && i_req_addr < zone_r) |=>
        ($past(i_req_addr[`LINE_BIT]) ? o_ch1_valid : o_ch0_valid)) else $error("low zone steering wrong");
    // requests above the zone reach the larger channel
    upper_zone_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (mode_r == MODE_ZONED && accept && i_req_addr >= zone_r) |=> ($past(big_r) ? o_ch1_valid : o_ch0_valid))
        else $error("upper zone wrong");
    // a population missing one channel never selects a dual mode
    dual_pop_a: assert property (@(posedge i_clk) disable iff (i_rst)
        $rose(i_cfg_load) ##0 (size0 == 5'h00 || size1 == 5'h00) |=> mode_r != MODE_ZONED && mode_r != MODE_SYMMETRIC)
        else $error("dual mode without both channels");
    // equal channels interleave the whole space
    sym_whole_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_cfg_load && size0 == size1 && size0 != 5'h00) |=> (mode_r == MODE_SYMMETRIC))
        else $error("equal channels not fully interleaved");
    // a refused population keeps the request side closed
    cfg_block_a: assert property (@(posedge i_clk) disable iff (i_rst)
        o_cfg_error |-> !o_req_ready) else $error("traffic taken despite refused population");
    // two modules on a channel always run at the double rate
    two_mod_rate_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (mods[0].present && mods[1].present) |-> o_ch0_timing.two_clk) else $error("two modules at single rate");
    two_mod_rate1_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (mods[2].present && mods[3].present) |-> o_ch1_timing.two_clk) else $error("two modules at single rate 1");
    // latched rate follows the slowest module and moves only on a load
    low_rate_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_cfg_load && slow_rate) |=> rate_r == `RATE_1066) else $error("rate above slowest module");
    rate_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
        !i_cfg_load |=> $stable(rate_r)) else $error("rate moved without a load");
    // a pending channel takes no second command
    one_pending_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (busy_r != 2'b00) |-> ((busy_r & issue) == 2'b00)) else $error("second command to a busy channel");
    // the idle channel still starts while the other one waits for data
    opposite_go_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (busy_r[0] && !busy_r[1] && pace_ok[1] && map_ok && i_req_valid && tgt) |=> o_ch1_valid)
        else $error("opposite channel blocked");
    // the upper rate always uses its single bin
    bin_1333_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (rate_r == `RATE_1333) |-> (o_ch0_timing.t_cl == `T_CL_1333 && o_ch1_timing.cwl == `CWL_1333))
        else $error("wrong bin at upper rate");
endmodule // ddr3_dual_channel_mapper

// ---- hw/ddr3_map_params.svh ----
// timing, encoding and geometry constants for the dual-channel mapper
`ifndef DDR3_MAP_PARAMS_SVH
`define DDR3_MAP_PARAMS_SVH
`define RATE_1066 1'b0
`define RATE_1333 1'b1
`define T_CL_1066_A 5'h07
`define T_RCD_1066_A 5'h07
`define T_RP_1066_A 5'h07
`define CWL_1066_A 5'h06
`define T_CL_1066_B 5'h08
`define T_RCD_1066_B 5'h08
`define T_RP_1066_B 5'h08
`define CWL_1066_B 5'h06
`define T_CL_1333 5'h09
`define T_RCD_1333 5'h09
`define T_RP_1333 5'h09
`define CWL_1333 5'h07
`define LINE_BIT 6
`define ROW_MIN 5'h0d
`define ROW_MAX 5'h10
`define COL_BITS 4'ha
`define BANK_BITS 2'h3
`define RANK_MAX 3'h4
`define CMD_GAP_2CLK 2'h2
`endif

// ---- hw/ddr3_map_pkg.sv ----
// types shared by the dual-channel mapper
package ddr3_map_pkg;
    // operating organisation
    typedef enum logic [1:0] {
        MODE_NONE,
        MODE_SINGLE,
        MODE_ZONED,
        MODE_SYMMETRIC
    } org_mode_t;
    // per-module population and capability from presence-detect data
    typedef struct packed {
        logic present;
        logic rate_1333;
        logic slow_bin;
        logic dual_rank;
        logic [4:0] row_bits;
        logic [3:0] size_gb;
    } module_info_t;
    // per-channel applied timing
    typedef struct packed {
        logic [4:0] t_cl;
        logic [4:0] t_rcd;
        logic [4:0] t_rp;
        logic [4:0] cwl;
        logic two_clk;
    } chan_timing_t;
    // request toward a channel
    typedef struct packed {
        logic [35:0] offset;
        logic write;
    } chan_req_t;
endpackage

// ---- hw/ddr3_cmd_pacer.sv ----
// per-channel command spacing for one- or two-clock command rate
`timescale 1ns/1ps
`include "ddr3_map_params.svh"
module ddr3_cmd_pacer (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // control
    input wire logic i_two_clk,
    input wire logic i_issue,
    // status
    output logic o_ready
);
    logic [1:0] gap_r; // cycles since last issue, saturating
    logic [1:0] gap_nxt;

    // count cycles after each issued command
    always_comb begin
        gap_nxt = gap_r;
        if (i_issue && o_ready) begin
            gap_nxt = 2'h1;
        end else if (gap_r != `CMD_GAP_2CLK) begin
            gap_nxt = gap_r + 2'h1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            gap_r <= `CMD_GAP_2CLK;
        end else begin
            gap_r <= gap_nxt;
        end
    end

    // single rate allows every clock, double rate every second clock
    assign o_ready = !i_two_clk || (gap_r == `CMD_GAP_2CLK);

    two_clk_gap_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_two_clk && i_issue && o_ready) |=> !o_ready) else $error("double rate issued back to back");
endmodule // ddr3_cmd_pacer

// ---- hw/ddr3_chan_timing.sv ----
// per-channel timing select: worst latency among modules at the common rate
`timescale 1ns/1ps
`include "ddr3_map_params.svh"
module ddr3_chan_timing
    import ddr3_map_pkg::*;
(
    // population of the two slots of this channel
    input ddr3_map_pkg::module_info_t i_slot0,
    input ddr3_map_pkg::module_info_t i_slot1,
    // common system rate
    input wire logic i_rate_1333,
    input wire logic i_want_one_clk,
    // applied timing
    output ddr3_map_pkg::chan_timing_t o_timing
);
    logic slow; // any present module needs the slower bin
    logic two_mod; // two modules on this channel

    always_comb begin
        slow = (i_slot0.present && i_slot0.slow_bin) || (i_slot1.present && i_slot1.slow_bin);
        two_mod = i_slot0.present && i_slot1.present;
        o_timing.two_clk = two_mod || !i_want_one_clk;
        if (i_rate_1333 == `RATE_1333) begin
            // only bin at the upper rate
            o_timing.t_cl = `T_CL_1333;
            o_timing.t_rcd = `T_RCD_1333;
            o_timing.t_rp = `T_RP_1333;
            o_timing.cwl = `CWL_1333;
        end else if (slow) begin
            // slower bin at the lower rate
            o_timing.t_cl = `T_CL_1066_B;
            o_timing.t_rcd = `T_RCD_1066_B;
            o_timing.t_rp = `T_RP_1066_B;
            o_timing.cwl = `CWL_1066_B;
        end else begin
            // faster bin at the lower rate
            o_timing.t_cl = `T_CL_1066_A;
            o_timing.t_rcd = `T_RCD_1066_A;
            o_timing.t_rp = `T_RP_1066_A;
            o_timing.cwl = `CWL_1066_A;
        end
    end
endmodule // ddr3_chan_timing

// ---- tb/ddr3_chan_model.sv ----
// behavioural model of the modules on one channel: completes each request after a fixed latency
`timescale 1ns/1ps
module ddr3_chan_model #(
    parameter int DELAY = 4
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // request strobe from the mapper, completion back to it
    input wire logic i_valid,
    output logic o_done
);
    int cnt_r; // cycles left on the outstanding request, 0 when idle
    // read data returns DELAY cycles after the command, as a one-cycle completion pulse
    always @(posedge i_clk) begin
        o_done <= 1'b0;
        if (i_rst) begin
            cnt_r <= 0;
        end else if (i_valid) begin
            cnt_r <= DELAY;
        end else if (cnt_r == 1) begin
            o_done <= 1'b1;
            cnt_r <= 0;
        end else if (cnt_r > 1) begin
            cnt_r <= cnt_r - 1;
        end
    end
endmodule // ddr3_chan_model

// ---- tb/ddr3_dual_channel_mapper_tb_top.sv ----
// self-checking testbench for the dual-channel mapper
`timescale 1ns/1ps
`include "ddr3_map_params.svh"
module ddr3_dual_channel_mapper_tb_top;
    import ddr3_map_pkg::*;
    // clock, reset and configuration
    logic i_clk, i_rst, i_cfg_load, i_want_one_clk, i_a_is_phys1;
    module_info_t m0, m1, m2, m3;
    // request side and completions
    logic i_req_valid, i_req_write, done0, done1;
    logic [35:0] i_req_addr;
    // design outputs
    logic o_req_ready, o_ch0_valid, o_ch1_valid, o_rate_1333, o_cfg_error;
    chan_req_t o_ch0_req, o_ch1_req;
    org_mode_t o_mode;
    chan_timing_t o_ch0_timing, o_ch1_timing;
    int err_count = 0;
    int n_compared = 0;
    localparam module_info_t NOMOD = '0; // empty slot

    ddr3_dual_channel_mapper i_dut (.i_clk(i_clk), .i_rst(i_rst), .i_mod0(m0), .i_mod1(m1), .i_mod2(m2),
        .i_mod3(m3), .i_cfg_load(i_cfg_load), .i_want_one_clk(i_want_one_clk), .i_a_is_phys1(i_a_is_phys1),
        .i_req_valid(i_req_valid), .i_req_addr(i_req_addr), .i_req_write(i_req_write), .o_req_ready(o_req_ready),
        .o_ch0_valid(o_ch0_valid), .o_ch0_req(o_ch0_req), .i_ch0_done(done0), .o_ch1_valid(o_ch1_valid),
        .o_ch1_req(o_ch1_req), .i_ch1_done(done1), .o_mode(o_mode), .o_rate_1333(o_rate_1333),
        .o_cfg_error(o_cfg_error), .o_ch0_timing(o_ch0_timing), .o_ch1_timing(o_ch1_timing));
    // channel 0 answers slowly, channel 1 promptly
    ddr3_chan_model #(.DELAY(10)) i_mem0 (.i_clk(i_clk), .i_rst(i_rst), .i_valid(o_ch0_valid), .o_done(done0));
    ddr3_chan_model #(.DELAY(3)) i_mem1 (.i_clk(i_clk), .i_rst(i_rst), .i_valid(o_ch1_valid), .o_done(done1));

    // 100 MHz clock
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    // compare one value and count it
    task automatic chk(input string nm, input logic [39:0] e, input logic [39:0] g);
        n_compared++;
        if (g !== e) begin
            err_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    // print counts and the verdict, then stop
    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // populated slot with the given speed, bin, rows and size
    function automatic module_info_t mk(input logic r13, input logic slow, input logic [4:0] rows,
        input logic [3:0] gb);
        mk = '{present: 1'b1, rate_1333: r13, slow_bin: slow, dual_rank: 1'b0, row_bits: rows, size_gb: gb};
    endfunction

    // drain traffic, apply a population and pulse the load
    task automatic cfg(input module_info_t a, input module_info_t b, input module_info_t c,
        input module_info_t d, input logic one, input logic ap1);
        repeat (16) @(posedge i_clk);
        m0 <= a;
        m1 <= b;
        m2 <= c;
        m3 <= d;
        i_want_one_clk <= one;
        i_a_is_phys1 <= ap1;
        @(posedge i_clk);
        i_cfg_load <= 1'b1;
        @(posedge i_clk);
        i_cfg_load <= 1'b0;
        @(posedge i_clk);
        #1;
    endtask

    // one request: held until taken, then the channel strobe and payload are judged
    task automatic do_req(input logic [35:0] a, input logic ch, input logic [35:0] off, input int max_wait);
        int n;
        n = 0;
        @(posedge i_clk);
        i_req_valid <= 1'b1;
        i_req_addr <= a;
        i_req_write <= a[3];
        #1;
        while (o_req_ready !== 1'b1 && n < 60) begin
            @(posedge i_clk);
            #1;
            n++;
        end
        @(posedge i_clk);
        i_req_valid <= 1'b0;
        #1;
        chk("late", 40'h1, {39'h0, n <= max_wait});
        chk("strobes", {38'h0, ch, !ch}, {38'h0, o_ch1_valid, o_ch0_valid});
        chk("payload", {3'h0, off, a[3]}, {3'h0, ch ? o_ch1_req : o_ch0_req});
    endtask

    // offset inside an interleaved region: line select bit squeezed out
    function automatic logic [35:0] ilv(input logic [35:0] a);
        ilv = {1'b0, a[35:7], a[5:0]};
    endfunction

    // state straight after reset
    task automatic t_reset();
        chk("mode", {38'h0, MODE_NONE}, {38'h0, o_mode});
        chk("idle", 40'h0, {36'h0, o_req_ready, o_cfg_error, o_rate_1333, o_ch0_valid | o_ch1_valid});
    endtask

    // one populated channel passes the address through unchanged, on either side
    task automatic t_single();
        cfg(mk(1'b1, 1'b0, 5'h0e, 4'h2), mk(1'b1, 1'b0, 5'h0e, 4'h2), NOMOD, NOMOD, 1'b1, 1'b0);
        chk("mode", {38'h0, MODE_SINGLE}, {38'h0, o_mode});
        chk("t0", {19'h0, `T_CL_1333, `T_RCD_1333, `T_RP_1333, `CWL_1333, 1'b1}, {19'h0, o_ch0_timing});
        do_req(36'h0_0000_0048, 1'b0, 36'h0_0000_0048, 0);
        do_req(36'h0_0000_0088, 1'b0, 36'h0_0000_0088, 60);
        cfg(NOMOD, NOMOD, mk(1'b1, 1'b0, 5'h0e, 4'h2), mk(1'b1, 1'b0, 5'h0e, 4'h2), 1'b1, 1'b1);
        chk("t1", {19'h0, `T_CL_1333, `T_RCD_1333, `T_RP_1333, `CWL_1333, 1'b1}, {19'h0, o_ch1_timing});
        do_req(36'h0_0000_0040, 1'b1, 36'h0_0000_0040, 0);
    endtask

    // equal channels of different densities interleave line by line
    task automatic t_sym();
        logic [35:0] a;
        cfg(mk(1'b1, 1'b0, 5'h0e, 4'h2), NOMOD, mk(1'b1, 1'b0, 5'h0f, 4'h2), NOMOD, 1'b1, 1'b0);
        chk("mode", {38'h0, MODE_SYMMETRIC}, {38'h0, o_mode});
        chk("rate", 40'h1, {39'h0, o_rate_1333});
        chk("t0", {19'h0, `T_CL_1333, `T_RCD_1333, `T_RP_1333, `CWL_1333, 1'b0}, {19'h0, o_ch0_timing});
        for (int k = 0; k < 4; k++) begin
            a = 36'h0_7000_0008 + 36'(k * 64);
            do_req(a, a[6], ilv(a), (k == 1) ? 0 : 60);
        end
    endtask

    // unequal channels: interleaved low zone, single-channel high zone, worst timing per channel
    task automatic t_zone();
        cfg(mk(1'b0, 1'b0, 5'h10, 4'h2), mk(1'b1, 1'b1, 5'h0e, 4'h2), mk(1'b1, 1'b0, 5'h0d, 4'h2), NOMOD,
            1'b1, 1'b0);
        chk("mode", {38'h0, MODE_ZONED}, {38'h0, o_mode});
        chk("rate", 40'h0, {39'h0, o_rate_1333});
        chk("t0", {19'h0, `T_CL_1066_B, `T_RCD_1066_B, `T_RP_1066_B, `CWL_1066_B, 1'b1},
            {19'h0, o_ch0_timing});
        chk("t1", {19'h0, `T_CL_1066_A, `T_RCD_1066_A, `T_RP_1066_A, `CWL_1066_A, 1'b0},
            {19'h0, o_ch1_timing});
        do_req(36'h0_4000_0040, 1'b1, ilv(36'h0_4000_0040), 0);
        do_req(36'h1_0000_0040, 1'b0, 36'h0_8000_0040, 0);
        do_req(36'h0_ffff_ffc0, 1'b1, ilv(36'h0_ffff_ffc0), 60);
    endtask

    // a refused population blocks all traffic
    task automatic refused(input module_info_t a, input logic ap1);
        cfg(a, NOMOD, mk(1'b1, 1'b0, 5'h0e, 4'h2), NOMOD, 1'b0, ap1);
        @(posedge i_clk);
        i_req_valid <= 1'b1;
        repeat (3) @(posedge i_clk);
        #1;
        chk("error", 40'h2, {38'h0, o_cfg_error, o_req_ready});
        chk("t1 rate", 40'h1, {39'h0, o_ch1_timing.two_clk});
        @(posedge i_clk);
        i_req_valid <= 1'b0;
    endtask

    // watchdog: the sequence needs well under 2000 cycles
    initial begin
        repeat (20000) @(posedge i_clk);
        err_count++;
        finish_test();
    end

    // main sequence
    initial begin
        i_rst = 1'b1;
        i_cfg_load = 1'b0;
        i_want_one_clk = 1'b0;
        i_a_is_phys1 = 1'b0;
        i_req_valid = 1'b0;
        i_req_write = 1'b0;
        i_req_addr = '0;
        m0 = NOMOD;
        m1 = NOMOD;
        m2 = NOMOD;
        m3 = NOMOD;
        repeat (2) @(posedge i_clk);
        i_rst <= 1'b0;
        @(posedge i_clk);
        #1;
        t_reset();
        t_single();
        t_sym();
        t_zone();
        refused(mk(1'b1, 1'b0, 5'h0e, 4'h4), 1'b1);
        refused(mk(1'b1, 1'b0, 5'h11, 4'h2), 1'b0);
        refused(mk(1'b1, 1'b0, 5'h0c, 4'h2), 1'b0);
        finish_test();
    end
endmodule // ddr3_dual_channel_mapper_tb_top
